/* src/regport_defs.vh */
// Constants for the terminal register access port
`ifndef REGPORT_DEFS_VH
`define REGPORT_DEFS_VH

// ============================================================
// Control and status byte fields
`define RP_MODE_BIT        7
`define RP_DIR_BIT         6
`define RP_NUM_MSB         5
`define RP_NUM_LSB         0
`define RP_NUM_W           6
`define RP_DIR_MASK        8'h40

// ============================================================
// Register numbers
`define RP_REG_TYPE        6'h08
`define RP_REG_FIRMWARE    6'h09
`define RP_REG_CODE_WORD   6'h1f
`define RP_REG_FEATURE     6'h20

// ============================================================
// Code word values
`define RP_UNLOCK_WORD     16'h1235
`define RP_RELOCK_WORD     16'h0000

// ============================================================
// Reset values
`define RP_CODE_WORD_RST   16'h0000
`define RP_FEATURE_RST     16'h0000
`define RP_STATUS_RST      8'h00
`define RP_WORD_RST        16'h0000

`endif

/* src/user_reg_bank.v */
// Stored user registers with code word write protection
`include "regport_defs.vh"
`default_nettype none

module user_reg_bank #(
    parameter [15:0] TYPE_ID   = 16'h0001,  // Arbitrary identification value
    parameter [15:0] FW_ID     = 16'h0001   // Arbitrary identification value
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Write request
    input  wire        wr_en,
    input  wire [5:0]  wr_num,
    input  wire [15:0] wr_data,
    // Read port
    input  wire [5:0]  rd_num,
    output reg  [15:0] rd_data,
    // Stored feature value and unlock flag
    output wire [15:0] feature_stored,
    output wire        unlocked
);

    // ============================================================
    // Storage
    reg [15:0] code_word_q;
    reg [15:0] feature_q;
    reg        unlocked_q;

    assign feature_stored = feature_q;
    assign unlocked       = unlocked_q;

    always @(posedge clk) begin
        if (rst) begin
            code_word_q <= `RP_CODE_WORD_RST;
            feature_q   <= `RP_FEATURE_RST;
            unlocked_q  <= 1'b0;
        end else if (wr_en) begin
            if (wr_num == `RP_REG_CODE_WORD) begin
                code_word_q <= wr_data;                                 // [R12]
                // Only the exact unlock word opens; 0x0000 and all else relock
                unlocked_q  <= (wr_data == `RP_UNLOCK_WORD);            // [R10] [R13]
            end else if (wr_num == `RP_REG_FEATURE && unlocked_q) begin
                feature_q   <= wr_data;                                 // [R11] [R12]
            end
        end
    end

    // ============================================================
    // Read mux; unmapped numbers read as zero
    always @* begin
        if (rd_num == `RP_REG_CODE_WORD) begin
            rd_data = code_word_q;
        end else if (rd_num == `RP_REG_FEATURE) begin
            rd_data = feature_q;                                        // [R11]
        end else if (rd_num == `RP_REG_TYPE) begin
            rd_data = TYPE_ID;
        end else if (rd_num == `RP_REG_FIRMWARE) begin
            rd_data = FW_ID;
        end else begin
            rd_data = 16'h0000;
        end
    end

endmodule // user_reg_bank

`default_nettype wire

/* src/terminal_register_access_port.v */
// Register communication engine of a bus terminal process image
`include "regport_defs.vh"
`default_nettype none

// Behaviour
// R1 - Control byte bit 7 high selects register communication instead of process data.
// R2 - Bit 6 high writes the register; low reads it without change.
// R3 - Bits 5..0 carry the binary register number, e.g. 32 as 10 0000.
// R4 - Write receipt is the control byte with bit 6 cleared.
// R5 - After a write receipt the partner ignores the input data word.
// R6 - Read receipt echoes the unmodified control byte.
// R7 - Read returns register contents, high byte in byte 1, low in byte 2.
// R8 - Output data word is ignored for reads.
// R9 - Output word high byte is byte 1, low byte 2; write stores it.
// R10 - Writing 0x0000 to register 31 re-enables write protection.
// R11 - Register 32 holds terminal-specific feature bits, same access protocol.
// R12 - User registers read-only unless register 31 holds 0x1235.
// R13 - Any other value written to register 31 restores write protection.
// R14 - Changed registers take effect only after the next power-up restart.
// R15 - Partner holds control byte and word until the receipt appears.
module terminal_register_access_port #(
    parameter [15:0] TYPE_ID = 16'h0001,    // Arbitrary identification value
    parameter [15:0] FW_ID   = 16'h0001     // Arbitrary identification value
) (
    // Clock and reset
    input  wire        MCLK,
    input  wire        SYS_RST,
    // Output process image from the coupler
    input  wire [7:0]  CTRL_BYTE,
    input  wire [7:0]  OUT_DATA_HI,
    input  wire [7:0]  OUT_DATA_LO,
    // Power-up restart request pin
    input  wire        POWER_UP_RESTART,
    // Input process image to the coupler
    output reg  [7:0]  STATUS_BYTE,
    output reg  [7:0]  IN_DATA_HI,
    output reg  [7:0]  IN_DATA_LO,
    // Feature bits in force and write unlock flag
    output reg  [15:0] FEATURE_ACTIVE,
    output reg         WRITE_UNLOCKED
);

    // ============================================================
    // Input capture
    // Process image comes from logic on MCLK, one stage only
    reg  [7:0]  ctrl_q;
    reg  [15:0] out_word_q;
    reg  [7:0]  last_ctrl_q;
    reg  [15:0] last_word_q;
    reg         seen_q;

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            ctrl_q     <= 8'h00;
            out_word_q <= 16'h0000;
        end else begin
            ctrl_q     <= CTRL_BYTE;
            out_word_q <= {OUT_DATA_HI, OUT_DATA_LO};                   // [R9]
        end
    end

    // ============================================================
    // Restart pin synchroniser and edge detect
    reg restart_meta_q;
    reg restart_sync_q;
    reg restart_prev_q;

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            restart_meta_q <= 1'b0;
            restart_sync_q <= 1'b0;
            restart_prev_q <= 1'b0;
        end else begin
            restart_meta_q <= POWER_UP_RESTART;
            restart_sync_q <= restart_meta_q;
            restart_prev_q <= restart_sync_q;
        end
    end

    wire restart_rise = restart_sync_q & ~restart_prev_q;

    // ============================================================
    // Command decode
    function [1:0] decode_cmd;
        input [7:0] cb;
        begin
            decode_cmd = {cb[`RP_MODE_BIT], cb[`RP_DIR_BIT]};
        end
    endfunction

    wire [1:0] cmd_kind = decode_cmd(ctrl_q);
    wire       reg_mode = cmd_kind[1];                                  // [R1]
    wire       is_write = cmd_kind[1] & cmd_kind[0];                    // [R2]
    wire [5:0] reg_num  = ctrl_q[`RP_NUM_MSB:`RP_NUM_LSB];              // [R3]

    // A command is new when the control byte or, for writes, the word changes.
    // The partner holding both stable lets one write execute once only.
    wire new_cmd = reg_mode &&
                   (!seen_q || ctrl_q != last_ctrl_q ||
                    (is_write && out_word_q != last_word_q));           // [R15]

    wire        bank_wr = new_cmd & is_write;
    wire [15:0] rd_data;
    wire [15:0] feature_stored;
    wire        unlocked;

    // ============================================================
    // Register storage
    user_reg_bank #(
        .TYPE_ID        (TYPE_ID),
        .FW_ID          (FW_ID)
    ) u_bank (
        .clk            (MCLK),
        .rst            (SYS_RST),
        .wr_en          (bank_wr),
        .wr_num         (reg_num),
        .wr_data        (out_word_q),                                   // [R9]
        .rd_num         (reg_num),
        .rd_data        (rd_data),
        .feature_stored (feature_stored),
        .unlocked       (unlocked)
    );

    // ============================================================
    // Command tracking
    reg [7:0]  last_ctrl_d;
    reg [15:0] last_word_d;
    reg        seen_d;

    always @* begin
        last_ctrl_d = last_ctrl_q;
        last_word_d = last_word_q;
        seen_d      = seen_q;
        if (!reg_mode) begin
            seen_d      = 1'b0;
        end else if (new_cmd) begin
            last_ctrl_d = ctrl_q;
            last_word_d = out_word_q;
            seen_d      = 1'b1;
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            last_ctrl_q <= 8'h00;
            last_word_q <= 16'h0000;
            seen_q      <= 1'b0;
        end else begin
            last_ctrl_q <= last_ctrl_d;
            last_word_q <= last_word_d;
            seen_q      <= seen_d;
        end
    end

    // ============================================================
    // Receipt and read data
    // Next values formed apart so the output flops see one clean mux
    reg [7:0] status_d;
    reg [7:0] in_hi_d;
    reg [7:0] in_lo_d;

    always @* begin
        status_d = STATUS_BYTE;
        in_hi_d  = IN_DATA_HI;
        in_lo_d  = IN_DATA_LO;
        if (!reg_mode) begin
            // Process data mode lies outside this block
            status_d = `RP_STATUS_RST;
            in_hi_d  = 8'h00;
            in_lo_d  = 8'h00;
        end else if (new_cmd) begin
            if (is_write) begin
                // Data word left as is; partner treats it as invalid
                status_d = ctrl_q & ~`RP_DIR_MASK;                      // [R4] [R5]
            end else begin
                status_d = ctrl_q;                                      // [R6] [R8]
                in_hi_d  = rd_data[15:8];                               // [R7]
                in_lo_d  = rd_data[7:0];                                // [R7]
            end
        end else if (!is_write) begin
            // Keep read data current while the read stays posted
            in_hi_d  = rd_data[15:8];                                   // [R7]
            in_lo_d  = rd_data[7:0];                                    // [R7]
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            STATUS_BYTE <= `RP_STATUS_RST;
            IN_DATA_HI  <= 8'h00;
            IN_DATA_LO  <= 8'h00;
        end else begin
            STATUS_BYTE <= status_d;
            IN_DATA_HI  <= in_hi_d;
            IN_DATA_LO  <= in_lo_d;
        end
    end

    // ============================================================
    // Behaviour in force
    // Stored features sit inside the bank and are cleared by SYS_RST; the
    // active copy changes only on a restart or SYS_RST, so a write never acts at once.
    reg [15:0] feature_d;

    always @* begin
        feature_d = FEATURE_ACTIVE;
        if (restart_rise) begin
            feature_d = feature_stored;                                 // [R14]
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            FEATURE_ACTIVE <= `RP_FEATURE_RST;
            WRITE_UNLOCKED <= 1'b0;
        end else begin
            WRITE_UNLOCKED <= unlocked;                                 // [R12]
            FEATURE_ACTIVE <= feature_d;
        end
    end

endmodule // terminal_register_access_port

`default_nettype wire

/* sim/regport_properties.sv */
// Checker of the register access port outputs
`default_nettype none
module regport_checker (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    // Process image in and out
    input wire logic [7:0]  CTRL_BYTE,
    input wire logic [7:0]  OUT_DATA_HI,
    input wire logic [7:0]  OUT_DATA_LO,
    input wire logic        POWER_UP_RESTART,
    input wire logic [7:0]  STATUS_BYTE,
    input wire logic [7:0]  IN_DATA_HI,
    input wire logic [7:0]  IN_DATA_LO,
    input wire logic [15:0] FEATURE_ACTIVE,
    input wire logic        WRITE_UNLOCKED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dflt @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // ============================================================
    // Receipts
    idle_out_a: assert property ((!CTRL_BYTE[7]) [*3] |-> STATUS_BYTE == 8'h00
        && {IN_DATA_HI, IN_DATA_LO} == 16'h0000) else $error("status not idle");
    mode_bit_a: assert property (STATUS_BYTE != 8'h00 |-> STATUS_BYTE[7]) else $error("receipt lacks mode");
    wr_receipt_a: assert property ((CTRL_BYTE[7:6] == 2'b11 && $stable(CTRL_BYTE)) [*2]
        |-> STATUS_BYTE == (CTRL_BYTE & 8'hbf)) else $error("bad write receipt");
    rd_receipt_a: assert property ((CTRL_BYTE[7:6] == 2'b10 && $stable(CTRL_BYTE)) [*2]
        |-> STATUS_BYTE == CTRL_BYTE) else $error("bad read receipt");
    // ============================================================
    // Protection and restart
    unlock_set_a: assert property ((CTRL_BYTE == 8'hdf && {OUT_DATA_HI, OUT_DATA_LO} == 16'h1235
        && $stable(CTRL_BYTE)) [*2] |=> WRITE_UNLOCKED) else $error("unlock missed");
    relock_set_a: assert property ((CTRL_BYTE == 8'hdf && {OUT_DATA_HI, OUT_DATA_LO} != 16'h1235
        && $stable(CTRL_BYTE)) [*2] |=> !WRITE_UNLOCKED) else $error("relock missed");
    unlock_cause_a: assert property ($rose(WRITE_UNLOCKED) |-> $past(CTRL_BYTE, 2) == 8'hdf
        && $past({OUT_DATA_HI, OUT_DATA_LO}, 2) == 16'h1235) else $error("unlock without code");
    feature_hold_a: assert property ($changed(FEATURE_ACTIVE)
        |-> $past(POWER_UP_RESTART, 3)) else $error("feature changed early");
    cover property (CTRL_BYTE == 8'hdf && WRITE_UNLOCKED);
    cover property (CTRL_BYTE == 8'he0 && STATUS_BYTE == 8'ha0);
    cover property ($rose(POWER_UP_RESTART));
endmodule // regport_checker
bind terminal_register_access_port regport_checker u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .CTRL_BYTE(CTRL_BYTE), .OUT_DATA_HI(OUT_DATA_HI), .OUT_DATA_LO(OUT_DATA_LO),
    .POWER_UP_RESTART(POWER_UP_RESTART), .STATUS_BYTE(STATUS_BYTE), .IN_DATA_HI(IN_DATA_HI),
    .IN_DATA_LO(IN_DATA_LO), .FEATURE_ACTIVE(FEATURE_ACTIVE), .WRITE_UNLOCKED(WRITE_UNLOCKED));
`default_nettype wire

/* sim/coupler_model.sv */
// Coupler side model exchanging process image bytes
`default_nettype none
module coupler_model (
    input wire logic       clk,
    input wire logic [7:0] sts,
    input wire logic [7:0] dhi,
    input wire logic [7:0] dlo,
    output logic [7:0]     ctrl,
    output logic [7:0]     hi,
    output logic [7:0]     lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  stat;
    logic [15:0] data;
    initial begin
        ctrl = 8'h00;
        {hi, lo} = 16'h0000;
    end
    // ============================================================
    // One command: bit 7 mode, bit 6 direction, 5..0 number
    task automatic xfer(input logic [7:0] cb, input logic [15:0] w);
        int n;
        n = 0;
        @(posedge clk);
        #2 ctrl = cb;
        {hi, lo} = w; // High byte first
        @(posedge clk);
        // Held until the receipt shows looked at between edges, never on one
        @(posedge clk);
        #1;
        while (sts === 8'h00 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        stat = sts;
        data = {dhi, dlo}; // Caller ignores this after writes
        // Release only after the edge at which the receipt is taken
        @(posedge clk);
        #2 ctrl = 8'h00;
        {hi, lo} = ~w; // Released word no longer shows the old value
        n = 0;
        // Dropping the mode bit lets an identical command run again
        while (sts !== 8'h00 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
endmodule // coupler_model
`default_nettype wire

/* sim/test_terminal_register_access_port.sv */
// Self-checking bench of the register access port
`default_nettype none
module test_terminal_register_access_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TYPE_V = 16'h0c01; // Arbitrary value
    localparam logic [15:0] FW_V = 16'h0302;   // Arbitrary value
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        restart = 1'b0;
    logic [7:0]  ctrl, ohi, olo, sts, ihi, ilo;
    logic [15:0] feat;
    logic        unl;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    always #12.5 mclk = ~mclk;
    terminal_register_access_port #(.TYPE_ID(TYPE_V), .FW_ID(FW_V)) DUT (.MCLK(mclk), .SYS_RST(sys_rst),
        .CTRL_BYTE(ctrl), .OUT_DATA_HI(ohi), .OUT_DATA_LO(olo), .POWER_UP_RESTART(restart),
        .STATUS_BYTE(sts), .IN_DATA_HI(ihi), .IN_DATA_LO(ilo), .FEATURE_ACTIVE(feat), .WRITE_UNLOCKED(unl));
    coupler_model P (.clk(mclk), .sts(sts), .dhi(ihi), .dlo(ilo), .ctrl(ctrl), .hi(ohi), .lo(olo));
    // ============================================================
    // Shared helpers
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task rd(input logic [5:0] num, input logic [15:0] exp);
        P.xfer({2'b10, num}, 16'h5aa5); // Junk word must not matter
        check({8'h00, P.stat}, {8'h00, 2'b10, num});
        check(P.data, exp);
    endtask
    task wr(input logic [5:0] num, input logic [15:0] w);
        P.xfer({2'b11, num}, w);
        check({8'h00, P.stat}, {8'h00, 2'b10, num});
    endtask
    // ============================================================
    // Scenarios
    task t_reset;
        rd(6'h1f, 16'h0000);
        rd(6'h20, 16'h0000);
        check({15'h0000, unl}, 16'h0000);
    endtask
    task t_ids;
        rd(6'h08, TYPE_V);
        rd(6'h09, FW_V);
        rd(6'h3f, 16'h0000);
    endtask
    task t_locked;
        wr(6'h20, 16'h0002);
        rd(6'h20, 16'h0000);
    endtask
    task t_unlock;
        wr(6'h1f, 16'h1235);
        check({15'h0000, unl}, 16'h0001);
        rd(6'h1f, 16'h1235);
        wr(6'h20, 16'h0002);
        rd(6'h20, 16'h0002);
        check(feat, 16'h0000);
    endtask
    task t_relock;
        logic [15:0] v [2];
        v = '{16'h0000, 16'h00ff};
        foreach (v[i]) begin
            wr(6'h1f, 16'h1235);
            wr(6'h1f, v[i]);
            rd(6'h1f, v[i]);
            check({15'h0000, unl}, 16'h0000);
            wr(6'h20, 16'h5555);
            rd(6'h20, 16'h0002);
        end
    endtask
    task t_restart;
        @(posedge mclk);
        #2 restart = 1'b1;
        repeat (6) @(posedge mclk);
        #2 restart = 1'b0;
        check(feat, 16'h0002);
    endtask
    task t_nomode;
        @(posedge mclk);
        #2 P.ctrl = 8'h9f;
        repeat (3) @(posedge mclk);
        #2 check({8'h00, sts}, 16'h009f);
        check({ihi, ilo}, 16'h00ff);
        P.ctrl = 8'h1f;
        repeat (3) @(posedge mclk);
        #2 check({8'h00, sts}, 16'h0000);
        check({ihi, ilo}, 16'h0000);
        P.ctrl = 8'h00;
    endtask
    // Ceiling well above the roughly 150 cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        #2 sys_rst = 1'b0;
        t_reset;
        t_ids;
        t_locked;
        t_unlock;
        t_relock;
        t_restart;
        t_nomode;
        close_out;
    end
endmodule // test_terminal_register_access_port
`default_nettype wire
